// >>> verilog/fbc_params.svh
// Purpose: Constants for the flash bus command interface.
// Assumes: Included by bare name from the design files.
// Notes:   Codes are those seen on the low data byte.
`ifndef FBC_PARAMS_SVH
`define FBC_PARAMS_SVH

`define FBC_CMD_PROG        8'h40
`define FBC_CMD_PROG_ALT    8'h10
`define FBC_CMD_ERASE       8'h20
`define FBC_CMD_CLR_STATUS  8'h50
`define FBC_CMD_CFG_SETUP   8'h60
`define FBC_CMD_READ_STATUS 8'h70
`define FBC_CMD_READ_PROT   8'h90
`define FBC_CMD_READ_QUERY  8'h98
`define FBC_CMD_SUSPEND     8'hB0
`define FBC_CMD_PROT_PROG   8'hC0
`define FBC_CMD_CONFIRM     8'hD0
`define FBC_CMD_READ_ARRAY  8'hFF
`define FBC_CMD_LOCK        8'h01
`define FBC_CMD_SET_RCR     8'h03
`define FBC_CMD_LOCK_DOWN   8'h2F

`define FBC_SR_READY        7
`define FBC_SR_ERASE_SUSP   6
`define FBC_SR_ERASE_ERR    5
`define FBC_SR_PROG_ERR     4
`define FBC_SR_SUPPLY_ERR   3
`define FBC_SR_PROG_SUSP    2
`define FBC_SR_LOCK_ERR     1
`define FBC_SR_RESET        8'h80
`define FBC_RCR_WAIT_POL    8
`define FBC_RCR_CLK_RISE    6
`define FBC_RCR_ASYNC       15
`define FBC_RCR_RESET       16'h8000
`define FBC_BANK_BIT        19

`endif

// >>> verilog/fbc_pkg.sv
// Purpose: Types for the flash bus command interface.
// Assumes: Nothing beyond the parameter header.
// Notes:   Holds the read mode and decoder state enumerations.
package fbc_pkg;
	typedef enum logic [2:0] {
		FBC_RD_ARRAY,
		FBC_RD_STATUS,
		FBC_RD_PROT,
		FBC_RD_QUERY
	} fbc_rdmode_t;

	typedef enum logic [2:0] {
		FBC_ST_IDLE,
		FBC_ST_PROG,
		FBC_ST_ERASE,
		FBC_ST_CFG,
		FBC_ST_PROT,
		FBC_ST_BUSY
	} fbc_state_t;
endpackage

// >>> verilog/fbc_sync.sv
// Purpose: Two flip-flop level synchroniser.
// Assumes: Input is asynchronous to i_clk.
// Notes:   The first stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none
module fbc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic [WIDTH-1:0] i_d,
	output var  logic [WIDTH-1:0] o_q
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge i_clk)
	begin
		meta_r <= i_d;
		o_q    <= meta_r;
	end
endmodule
`default_nettype wire

// >>> verilog/fbc_burst_latch.sv
// Purpose: Burst address capture on the link clock.
// Assumes: i_link_clk runs only during burst frames.
// Notes:   Captures on the chosen clock edge while addr_valid_n is low.
`timescale 1ns/100ps
`default_nettype none
module fbc_burst_latch #(
	parameter int AW = 21
) (
	input  wire logic          i_link_clk,
	input  wire logic          i_rise_sel,
	input  wire logic          i_enable,
	input  wire logic          i_addr_valid_n,
	input  wire logic [AW-1:0] i_addr,
	output var  logic [AW-1:0] o_addr,
	output var  logic          o_toggle
);
	logic [AW-1:0] addr_rise_r;
	logic [AW-1:0] addr_fall_r;
	logic          tog_rise_r = 1'b0;
	logic          tog_fall_r = 1'b0;

	// Only the configured edge captures; the select also picks that edge's register for o_addr.
	always_ff @(posedge i_link_clk)
	begin
		if (i_enable && !i_addr_valid_n && i_rise_sel)
		begin
			addr_rise_r <= i_addr;
			tog_rise_r  <= !tog_rise_r;
		end
	end

	always_ff @(negedge i_link_clk)
	begin
		if (i_enable && !i_addr_valid_n && !i_rise_sel)
		begin
			addr_fall_r <= i_addr;
			tog_fall_r  <= !tog_fall_r;
		end
	end

	assign o_addr   = i_rise_sel ? addr_rise_r : addr_fall_r;
	assign o_toggle = tog_rise_r ^ tog_fall_r;
endmodule
`default_nettype wire

// >>> verilog/fbc_command_if.sv
// Purpose: Pin interface and command decoder of a dual bank flash.
// Assumes: Pins are asynchronous to i_clk; the burst clock is i_link_clk.
// Notes:   The engine and array sit outside; this block steers them.
`timescale 1ns/100ps
`default_nettype none
`include "fbc_params.svh"
module fbc_command_if
	import fbc_pkg::*;
#(
	parameter int AW = 21,
	parameter int DW = 16
) (
	input  wire logic          i_clk,
	input  wire logic          i_sys_rst,
	input  wire logic          i_link_clk,
	input  wire logic [AW-1:0] i_addr_lines,
	input  wire logic          i_chip_sel_n,
	input  wire logic          i_out_en_n,
	input  wire logic          i_write_n,
	input  wire logic          i_addr_valid_n,
	input  wire logic          i_reset_n,
	input  wire logic          i_write_protect_n,
	input  wire logic [DW-1:0] i_data_lines,
	output logic      [DW-1:0] o_data_lines,
	output logic               o_data_lines_oe_n,
	output logic               o_wait,
	input  wire logic [DW-1:0] i_array_data,
	input  wire logic [DW-1:0] i_info_data,
	input  wire logic          i_burst_data_valid,
	input  wire logic          i_engine_done,
	input  wire logic          i_engine_bank,
	input  wire logic [5:0]    i_engine_err,
	output logic               o_engine_rst,
	output logic               o_prog_start,
	output logic               o_erase_start,
	output logic               o_suspend,
	output logic               o_resume,
	output logic [AW-1:0]      o_op_addr,
	output logic [DW-1:0]      o_op_data,
	output logic               o_lock_all,
	output logic               o_block_lock,
	output logic               o_block_unlock,
	output logic               o_block_lock_down,
	output logic               o_lock_down_active,
	output logic               o_prot_prog,
	output logic [AW-1:0]      o_read_addr,
	output fbc_rdmode_t        o_read_mode,
	output logic [DW-1:0]      o_read_cfg
);
	logic [AW-1:0] addr_s;
	logic [DW-1:0] data_s;
	logic          cs_n_s;
	logic          oe_n_s;
	logic          we_n_s;
	logic          adv_n_s;
	logic          rst_n_s;
	logic          wp_n_s;
	logic          bdv_s;
	logic          rst_n_d_r;
	logic          we_n_d_r;
	logic          adv_n_d_r;
	logic          rd_act_d_r;
	logic          burst_mode;
	logic          write_ev;
	logic          read_start;
	logic          adv_rise;
	logic          burst_tog_s;
	logic          burst_tog_d_r;
	logic [AW-1:0] burst_addr;
	logic [AW-1:0] addr_r;
	logic [7:0]    code;
	fbc_state_t    state_r;
	fbc_rdmode_t   mode_r;
	logic          stat_bank_r;
	logic [7:0]    status_r [2];
	logic [7:0]    stat_lat_r;
	logic [DW-1:0] rcr_r;

	fbc_sync #(.WIDTH(AW + DW + 7)) u_sync (
		.i_clk (i_clk),
		.i_d   ({i_addr_lines, i_data_lines, i_chip_sel_n, i_out_en_n, i_write_n,
			i_addr_valid_n, i_reset_n, i_write_protect_n, i_burst_data_valid}),
		.o_q   ({addr_s, data_s, cs_n_s, oe_n_s, we_n_s, adv_n_s, rst_n_s, wp_n_s, bdv_s})
	);

	// The link clock logic is gated off unless burst mode is configured.
	assign burst_mode = !rcr_r[`FBC_RCR_ASYNC];

	fbc_burst_latch #(.AW(AW)) u_burst (
		.i_link_clk     (i_link_clk),
		.i_rise_sel     (rcr_r[`FBC_RCR_CLK_RISE]),
		.i_enable       (burst_mode && !i_chip_sel_n && i_reset_n),
		.i_addr_valid_n (i_addr_valid_n),
		.i_addr         (i_addr_lines),
		.o_addr         (burst_addr),
		.o_toggle       (burst_tog_s)
	);

	logic burst_tog_m_r;
	logic burst_tog_q_r;

	always_ff @(posedge i_clk)
	begin
		burst_tog_m_r <= burst_tog_s;
		burst_tog_q_r <= burst_tog_m_r;
		burst_tog_d_r <= burst_tog_q_r;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			rst_n_d_r  <= 1'b0;
			we_n_d_r   <= 1'b1;
			adv_n_d_r  <= 1'b1;
			rd_act_d_r <= 1'b0;
		end
		else
		begin
			rst_n_d_r  <= rst_n_s;
			we_n_d_r   <= we_n_s;
			adv_n_d_r  <= adv_n_s;
			rd_act_d_r <= !cs_n_s && !oe_n_s;
		end
	end

	// A write completes on the rising write strobe with the chip selected.
	assign write_ev   = rst_n_s && !cs_n_s && we_n_s && !we_n_d_r;
	assign read_start = rst_n_s && !cs_n_s && !oe_n_s && !rd_act_d_r;
	assign adv_rise   = adv_n_s && !adv_n_d_r;
	assign code       = data_s[7:0];

	// Address follows the lines while the strobe is low; after it rises it holds unless burst mode loads the link clock capture.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			addr_r <= '0;
		else if (burst_mode && (burst_tog_q_r != burst_tog_d_r) && adv_n_d_r)
			addr_r <= burst_addr;
		else if (!cs_n_s && (!adv_n_s || adv_rise) && !(burst_mode && adv_n_d_r && !adv_n_s))
			addr_r <= addr_s;
	end

	function automatic logic bank_of(input logic [AW-1:0] a);
		return a[`FBC_BANK_BIT];
	endfunction

	// Command decoder.
	always_ff @(posedge i_clk)
	begin
		o_prog_start      <= 1'b0;
		o_erase_start     <= 1'b0;
		o_suspend         <= 1'b0;
		o_resume          <= 1'b0;
		o_block_lock      <= 1'b0;
		o_block_unlock    <= 1'b0;
		o_block_lock_down <= 1'b0;
		o_prot_prog       <= 1'b0;
		o_lock_all        <= 1'b0;
		if (i_sys_rst || !rst_n_s)
		begin
			state_r     <= FBC_ST_IDLE;
			mode_r      <= FBC_RD_ARRAY;
			stat_bank_r <= 1'b0;
			rcr_r       <= `FBC_RCR_RESET;
			o_op_addr   <= '0;
			o_op_data   <= '0;
			o_lock_all  <= i_sys_rst;
		end
		else if (rst_n_s && !rst_n_d_r)
		begin
			o_lock_all <= 1'b1;
			mode_r     <= FBC_RD_ARRAY;
			state_r    <= FBC_ST_IDLE;
		end
		else if (write_ev)
		begin
			unique case (state_r)
				FBC_ST_IDLE:
				begin
					stat_bank_r <= bank_of(addr_r);
					unique case (code)
						`FBC_CMD_PROG, `FBC_CMD_PROG_ALT: state_r <= FBC_ST_PROG;
						`FBC_CMD_ERASE:       state_r <= FBC_ST_ERASE;
						`FBC_CMD_CFG_SETUP:   state_r <= FBC_ST_CFG;
						`FBC_CMD_PROT_PROG:   state_r <= FBC_ST_PROT;
						`FBC_CMD_READ_STATUS: mode_r <= FBC_RD_STATUS;
						`FBC_CMD_READ_PROT:   mode_r <= FBC_RD_PROT;
						`FBC_CMD_READ_QUERY:  mode_r <= FBC_RD_QUERY;
						`FBC_CMD_READ_ARRAY:  mode_r <= FBC_RD_ARRAY;
						`FBC_CMD_CONFIRM:     o_resume <= 1'b1;
						`FBC_CMD_SUSPEND:     o_suspend <= 1'b1;
						default:;
					endcase
				end
				FBC_ST_PROG:
				begin
					o_op_addr    <= addr_r;
					o_op_data    <= data_s;
					o_prog_start <= 1'b1;
					mode_r       <= FBC_RD_STATUS;
					state_r      <= FBC_ST_BUSY;
				end
				FBC_ST_ERASE:
				begin
					o_op_addr <= addr_r;
					mode_r    <= FBC_RD_STATUS;
					if (code == `FBC_CMD_CONFIRM)
					begin
						o_erase_start <= 1'b1;
						state_r       <= FBC_ST_BUSY;
					end
					else
						state_r <= FBC_ST_IDLE;
				end
				FBC_ST_CFG:
				begin
					o_op_addr <= addr_r;
					state_r   <= FBC_ST_IDLE;
					unique case (code)
						`FBC_CMD_LOCK:      o_block_lock <= 1'b1;
						`FBC_CMD_CONFIRM:   o_block_unlock <= 1'b1;
						`FBC_CMD_LOCK_DOWN: o_block_lock_down <= 1'b1;
						`FBC_CMD_SET_RCR:   rcr_r <= addr_r[DW-1:0];
						default:            mode_r <= FBC_RD_STATUS;
					endcase
				end
				FBC_ST_PROT:
				begin
					o_op_addr   <= addr_r;
					o_op_data   <= data_s;
					o_prot_prog <= 1'b1;
					state_r     <= FBC_ST_IDLE;
				end
				FBC_ST_BUSY:
				begin
					// Only status read and suspend are taken while the engine runs.
					if (code == `FBC_CMD_READ_STATUS)
					begin
						mode_r      <= FBC_RD_STATUS;
						stat_bank_r <= bank_of(addr_r);
					end
					else if (code == `FBC_CMD_SUSPEND)
						o_suspend <= 1'b1;
				end
				default: state_r <= FBC_ST_IDLE;
			endcase
		end
		else if (state_r == FBC_ST_BUSY && i_engine_done)
			state_r <= FBC_ST_IDLE;
	end

	// Per-bank status; engine sets win over the clear command.
	genvar b;
	generate
		for (b = 0; b < 2; b++)
		begin : g_status
			logic clr;
			logic hit;
			assign clr = write_ev && state_r == FBC_ST_IDLE && code == `FBC_CMD_CLR_STATUS
				&& bank_of(addr_r) == 1'(b);
			assign hit = i_engine_bank == 1'(b);
			always_ff @(posedge i_clk)
			begin
				if (i_sys_rst || !rst_n_s)
					status_r[b] <= `FBC_SR_RESET;
				else
				begin
					if (clr)
					begin
						status_r[b][`FBC_SR_LOCK_ERR]   <= 1'b0;
						status_r[b][`FBC_SR_SUPPLY_ERR] <= 1'b0;
						status_r[b][`FBC_SR_PROG_ERR]   <= 1'b0;
						status_r[b][`FBC_SR_ERASE_ERR]  <= 1'b0;
					end
					if (bank_of(o_op_addr) == 1'(b) && (o_prog_start || o_erase_start))
						status_r[b][`FBC_SR_READY] <= 1'b0;
					if (hit && i_engine_done)
					begin
						status_r[b][`FBC_SR_READY] <= 1'b1;
						status_r[b][`FBC_SR_ERASE_SUSP:`FBC_SR_LOCK_ERR] <= i_engine_err |
							(status_r[b][`FBC_SR_ERASE_SUSP:`FBC_SR_LOCK_ERR] & ~(clr ? 6'h1D : 6'h00));
					end
				end
			end
		end
	endgenerate

	// Status snapshot at the start of each read or at the end of each burst address phase.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			stat_lat_r <= '0;
		else if (read_start || (burst_mode && adv_rise))
			stat_lat_r <= status_r[stat_bank_r];
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst || !rst_n_s)
			o_data_lines <= '0;
		else if (mode_r == FBC_RD_STATUS)
			o_data_lines <= {8'h00, stat_lat_r};
		else if (mode_r == FBC_RD_ARRAY)
			o_data_lines <= i_array_data;
		else
			o_data_lines <= i_info_data;
	end

	assign o_data_lines_oe_n = !(rst_n_s && !cs_n_s && !oe_n_s && we_n_s);

	// Wait never floats: polarity level when idle or not bursting.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			o_wait <= 1'b0;
		else if (burst_mode && !cs_n_s && !oe_n_s && rst_n_s)
			o_wait <= bdv_s ~^ rcr_r[`FBC_RCR_WAIT_POL];
		else
			o_wait <= rcr_r[`FBC_RCR_WAIT_POL];
	end

	assign o_engine_rst       = i_sys_rst || !rst_n_s;
	assign o_lock_down_active = !wp_n_s;
	assign o_read_addr        = addr_r;
	assign o_read_mode        = mode_r;
	assign o_read_cfg         = rcr_r;
endmodule
`default_nettype wire

// >>> tb/fbc_host_model.sv
// Purpose: Host bus model that drives the flash pins.
// Assumes: Pins other than the link clock change 1 ns after i_clk rises.
// Notes:   Released data lines show the inverse of the last driven word.
`timescale 1ns/100ps
`default_nettype none
module fbc_host_model (
	input  wire logic        i_clk,
	input  wire logic [15:0] i_dev_data,
	input  wire logic        i_dev_oe_n,
	output var  logic [20:0] o_addr,
	output var  logic        o_cs_n,
	output var  logic        o_oe_n,
	output var  logic        o_we_n,
	output var  logic        o_adv_n,
	output var  logic        o_link_clk,
	output wire logic [15:0] o_data
);
	logic [15:0] drv = 16'h0000;
	logic        drv_en = 1'b0;
	initial
	begin
		{o_cs_n, o_oe_n, o_we_n, o_adv_n, o_link_clk} = 5'h1E;
		o_addr = 21'h0_0000;
	end
	assign o_data = !i_dev_oe_n ? i_dev_data : (drv_en ? drv : ~drv);
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic wr(input logic [20:0] a, input logic [15:0] d, input logic sel_n);
		step(1);
		o_addr = a;
		drv = d;
		drv_en = 1'b1;
		{o_cs_n, o_adv_n, o_we_n} = {sel_n, 2'b00};
		step(4);
		o_adv_n = 1'b1;
		step(4);
		o_we_n = 1'b1;
		step(4);
		{o_cs_n, drv_en} = 2'b10;
		step(4);
	endtask
	task automatic rd(input logic [20:0] a, output logic [15:0] d);
		step(1);
		o_addr = a;
		{o_cs_n, o_adv_n} = 2'b00;
		step(4);
		{o_adv_n, o_oe_n} = 2'b10;
		step(8);
		d = o_data;
		{o_cs_n, o_oe_n} = 2'b11;
		step(4);
	endtask
	task automatic burst(input logic [20:0] a);
		step(1);
		o_addr = a;
		{o_cs_n, o_adv_n} = 2'b00;
		repeat (4) #24 o_link_clk = ~o_link_clk;
		step(1);
		{o_adv_n, o_oe_n} = 2'b10;
		step(8);
	endtask
	task automatic idle();
		{o_cs_n, o_oe_n} = 2'b11;
		step(4);
	endtask
endmodule
`default_nettype wire

// >>> tb/fbc_command_if_properties.sv
// Purpose: Assertions on the pins and steering outputs.
// Assumes: Pins pass two sync flops before use.
// Notes:   Bound to every instance of the command interface.
`timescale 1ns/100ps
`default_nettype none
`include "fbc_params.svh"
module fbc_command_if_properties
	import fbc_pkg::*;
#(
	parameter int AW = 21,
	parameter int DW = 16
) (
	input wire logic          i_clk,
	input wire logic          i_sys_rst,
	input wire logic          i_chip_sel_n,
	input wire logic          i_out_en_n,
	input wire logic          i_write_n,
	input wire logic          i_reset_n,
	input wire logic          i_write_protect_n,
	input wire logic [DW-1:0] o_data_lines,
	input wire logic          o_data_lines_oe_n,
	input wire logic          o_wait,
	input wire logic          o_engine_rst,
	input wire logic          o_prog_start,
	input wire logic          o_erase_start,
	input wire logic          o_lock_down_active,
	input wire logic          o_lock_all,
	input wire fbc_rdmode_t   o_read_mode,
	input wire logic [DW-1:0] o_read_cfg
);
	logic [3:0] since_wr_r;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);
	// Counts cycles since the last selected write strobe rise.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			since_wr_r <= 4'hF;
		else if ($rose(i_write_n) && !i_chip_sel_n)
			since_wr_r <= 4'h0;
		else if (since_wr_r != 4'hF)
			since_wr_r <= since_wr_r + 4'h1;
	end
	sequence s_oe_off;
		i_out_en_n [*4];
	endsequence
	sequence s_pin_reset;
		!i_reset_n [*4];
	endsequence
	sequence s_cfg_async;
		(o_read_cfg[`FBC_RCR_ASYNC] && $stable(o_read_cfg)) [*2];
	endsequence
	a_oe_float: assert property (s_oe_off |-> o_data_lines_oe_n)
		else $error("data driven while output enable high");
	a_reset_float: assert property (s_pin_reset |-> o_data_lines_oe_n && o_engine_rst)
		else $error("pin reset did not float outputs and hold engine");
	a_release_lock: assert property ($rose(i_reset_n) |-> ##[1:6] o_lock_all)
		else $error("no lock all after reset release");
	a_wp_lockdown: assert property ($stable(i_write_protect_n) [*4] |-> o_lock_down_active == !i_write_protect_n)
		else $error("lock down does not follow write protect");
	a_wait_level: assert property (s_cfg_async |-> o_wait == o_read_cfg[`FBC_RCR_WAIT_POL])
		else $error("wait not at polarity level in async mode");
	a_start_cause: assert property ((o_prog_start || o_erase_start) |-> since_wr_r <= 4'h6)
		else $error("operation started without a write");
	a_standby_quiet: assert property (i_chip_sel_n [*8] |-> !o_prog_start && !o_erase_start)
		else $error("operation started while deselected");
	a_status_upper: assert property ((o_read_mode == FBC_RD_STATUS && !o_data_lines_oe_n) [*4]
		|-> o_data_lines[DW-1:8] == 8'h00)
		else $error("upper byte not zero in status read");
	a_data_hold: assert property (!o_data_lines_oe_n [*4] |-> $stable(o_data_lines))
		else $error("read data changed during read");
endmodule
bind fbc_command_if fbc_command_if_properties #(.AW(AW), .DW(DW)) chk_inst (
	.i_clk(i_clk),
	.i_sys_rst(i_sys_rst),
	.i_chip_sel_n(i_chip_sel_n),
	.i_out_en_n(i_out_en_n),
	.i_write_n(i_write_n),
	.i_reset_n(i_reset_n),
	.i_write_protect_n(i_write_protect_n),
	.o_data_lines(o_data_lines),
	.o_data_lines_oe_n(o_data_lines_oe_n),
	.o_wait(o_wait),
	.o_engine_rst(o_engine_rst),
	.o_prog_start(o_prog_start),
	.o_erase_start(o_erase_start),
	.o_lock_down_active(o_lock_down_active),
	.o_lock_all(o_lock_all),
	.o_read_mode(o_read_mode),
	.o_read_cfg(o_read_cfg)
);
`default_nettype wire

// >>> tb/fbc_command_if_tb.sv
// Purpose: Self-checking bench for the command interface.
// Assumes: Host model drives the bus pins; bench drives reset, write protect and the engine side.
// Notes:   Each command takes about 17 clocks.
`timescale 1ns/100ps
`default_nettype none
module fbc_command_if_tb;
	import fbc_pkg::*;
	logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_reset_n = 1'b1, i_write_protect_n = 1'b1;
	logic        i_burst_data_valid = 1'b0, i_engine_done = 1'b0, i_engine_bank = 1'b0;
	logic [5:0]  i_engine_err = 6'h00;
	logic [15:0] i_array_data = 16'hA5C3, i_info_data = 16'h3C5A, d;
	logic [8:0]  seen = 9'h000;
	int          n_errors = 0, checks_done = 0;
	wire logic [20:0] addr, op_addr, rd_addr;
	wire logic [15:0] dq, dout, op_data, cfg;
	wire logic   cs_n, oe_n, we_n, adv_n, lclk, dq_oe_n, wt, erst, pg, er, sus, res, lk, ul, ld, lda, pp, lall;
	wire fbc_rdmode_t rmode;
	logic [15:0] c1 [7] = '{16'h0040, 16'h0010, 16'h0020, 16'h0060, 16'h0060, 16'h0060, 16'h00C0};
	logic [15:0] c2 [7] = '{16'h1234, 16'hBEEF, 16'h00D0, 16'h0001, 16'h00D0, 16'h002F, 16'h5A5A};
	int          ix [7] = '{0, 0, 1, 2, 3, 4, 5};
	logic [15:0] mc [4] = '{16'h0090, 16'h0098, 16'h0070, 16'h00FF};
	logic [15:0] md [4] = '{16'h3C5A, 16'h3C5A, 16'h0080, 16'hA5C3};
	fbc_rdmode_t me [4] = '{FBC_RD_PROT, FBC_RD_QUERY, FBC_RD_STATUS, FBC_RD_ARRAY};
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk) seen <= seen | {lall, res, sus, pp, ld, ul, lk, er, pg};
	fbc_host_model fbc_host_model_inst (.i_clk(i_clk), .i_dev_data(dout), .i_dev_oe_n(dq_oe_n), .o_addr(addr),
		.o_cs_n(cs_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_adv_n(adv_n), .o_link_clk(lclk), .o_data(dq));
	fbc_command_if fbc_command_if_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_link_clk(lclk),
		.i_addr_lines(addr), .i_chip_sel_n(cs_n), .i_out_en_n(oe_n), .i_write_n(we_n), .i_addr_valid_n(adv_n),
		.i_reset_n(i_reset_n), .i_write_protect_n(i_write_protect_n), .i_data_lines(dq), .o_data_lines(dout),
		.o_data_lines_oe_n(dq_oe_n), .o_wait(wt), .i_array_data(i_array_data), .i_info_data(i_info_data),
		.i_burst_data_valid(i_burst_data_valid), .i_engine_done(i_engine_done), .i_engine_bank(i_engine_bank),
		.i_engine_err(i_engine_err), .o_engine_rst(erst), .o_prog_start(pg), .o_erase_start(er), .o_suspend(sus),
		.o_resume(res), .o_op_addr(op_addr), .o_op_data(op_data), .o_lock_all(lall), .o_block_lock(lk),
		.o_block_unlock(ul), .o_block_lock_down(ld), .o_lock_down_active(lda), .o_prot_prog(pp),
		.o_read_addr(rd_addr), .o_read_mode(rmode), .o_read_cfg(cfg));
	task automatic wrap_up();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk_w(input logic [20:0] g, input logic [20:0] e);
		checks_done++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_m(input fbc_rdmode_t g, input fbc_rdmode_t e);
		chk_w(21'(g), 21'(e));
	endtask
	task automatic cmd(input logic [20:0] a, input logic [15:0] c);
		fbc_host_model_inst.wr(a, c, 1'b0);
	endtask
	task automatic done_pulse(input logic b, input logic [5:0] e);
		@(posedge i_clk);
		#1;
		{i_engine_bank, i_engine_err, i_engine_done} = {b, e, 1'b1};
		@(posedge i_clk);
		#1;
		i_engine_done = 1'b0;
		repeat (4) @(posedge i_clk);
	endtask
	initial
	begin
		#200_000;
		n_errors++;
		$display("mismatch t=%0t watchdog expired", $time);
		wrap_up();
	end
	initial
	begin
		repeat (12) @(posedge i_clk);
		#1;
		i_sys_rst = 1'b0;
		repeat (4) @(posedge i_clk);
		chk_m(rmode, FBC_RD_ARRAY);
		chk_w(21'(cfg), 21'h0_8000);
		for (int k = 0; k < 4; k++)
		begin
			cmd(21'h0_0010, mc[k]);
			chk_m(rmode, me[k]);
			fbc_host_model_inst.rd(21'h0_0155 + 21'(k), d);
			chk_w(21'(d), 21'(md[k]));
			chk_w(rd_addr, 21'h0_0155 + 21'(k));
		end
		fbc_host_model_inst.wr(21'h0_0010, 16'h0090, 1'b1);
		chk_m(rmode, FBC_RD_ARRAY);
		for (int k = 0; k < 7; k++)
		begin
			seen = 9'h000;
			cmd(21'h0_0100 + 21'(k), c1[k]);
			cmd(21'h0_0100 + 21'(k), c2[k]);
			chk_w(21'(seen), 21'(1 << ix[k]));
			if (k < 2)
			begin
				chk_w(21'(op_data), 21'(c2[k]));
				chk_w(op_addr, 21'h0_0100 + 21'(k));
			end
			done_pulse(1'b0, 6'h00);
		end
		seen = 9'h000;
		cmd(21'h0_0200, 16'h0020);
		cmd(21'h0_0200, 16'h00FF);
		chk_w(21'(seen), 21'h0_0000);
		chk_m(rmode, FBC_RD_STATUS);
		cmd(21'h0_0200, 16'h0040);
		cmd(21'h0_0200, 16'h0077);
		cmd(21'h0_0200, 16'h00FF);
		chk_m(rmode, FBC_RD_STATUS);
		cmd(21'h0_0200, 16'h00B0);
		chk_w(21'(seen[6]), 21'h0_0001);
		done_pulse(1'b0, 6'h00);
		cmd(21'h0_0200, 16'h00D0);
		chk_w(21'(seen[7]), 21'h0_0001);
		done_pulse(1'b0, 6'h00);
		cmd(21'h8_0300, 16'h0040);
		cmd(21'h8_0300, 16'h0001);
		done_pulse(1'b1, 6'h1D);
		cmd(21'h8_0000, 16'h0070);
		fbc_host_model_inst.rd(21'h8_0000, d);
		chk_w(21'(d), 21'h0_00BA);
		cmd(21'h0_0000, 16'h0070);
		fbc_host_model_inst.rd(21'h0_0000, d);
		chk_w(21'(d), 21'h0_0080);
		cmd(21'h8_0000, 16'h0050);
		cmd(21'h8_0000, 16'h0070);
		fbc_host_model_inst.rd(21'h8_0000, d);
		chk_w(21'(d), 21'h0_0080);
		i_write_protect_n = 1'b0;
		repeat (6) @(posedge i_clk);
		chk_w(21'(lda), 21'h0_0001);
		#1;
		i_write_protect_n = 1'b1;
		cmd(21'h0_0140, 16'h0060);
		cmd(21'h0_0140, 16'h0003);
		chk_w(21'(cfg), 21'h0_0140);
		i_burst_data_valid = 1'b1;
		fbc_host_model_inst.burst(21'h0_0ABC);
		chk_w(rd_addr, 21'h0_0ABC);
		chk_w(21'(wt), 21'h0_0001);
		i_burst_data_valid = 1'b0;
		repeat (6) @(posedge i_clk);
		#1;
		chk_w(21'(wt), 21'h0_0000);
		fbc_host_model_inst.idle();
		cmd(21'h0_8000, 16'h0060);
		cmd(21'h0_8000, 16'h0003);
		chk_w(21'(wt), 21'h0_0000);
		cmd(21'h0_0010, 16'h0098);
		i_reset_n = 1'b0;
		repeat (6) @(posedge i_clk);
		chk_w(21'({dq_oe_n, erst}), 21'h0_0003);
		#1;
		seen = 9'h000;
		i_reset_n = 1'b1;
		repeat (8) @(posedge i_clk);
		chk_w(21'(seen[8]), 21'h0_0001);
		chk_m(rmode, FBC_RD_ARRAY);
		wrap_up();
	end
endmodule
`default_nettype wire
